// file: verilog/ncps_pkg.sv
// package: register map, field layout and carrier types of the nc/plc status block
package ncps_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned NPORT = 3;
  localparam int unsigned NIRQ = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TOOL_RANGE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] MACRO_CFG_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] LAST_CODE_OFS = 8'h18;

  // control register bits (write one to act, read as zero)
  localparam int unsigned CTRL_ACK_BIT = 0;
  localparam int unsigned CTRL_MAG1_BIT = 1;
  localparam int unsigned CTRL_MAG2_BIT = 2;

  // tool range fields
  localparam int unsigned TR_MIN_LSB = 0;
  localparam int unsigned TR_MAX_LSB = 8;
  localparam logic [CODE_W-1:0] TR_MIN_RST = 8'h01;
  localparam logic [CODE_W-1:0] TR_MAX_RST = 8'h10;

  // macro configuration fields
  localparam int unsigned MC_MCODE_LSB = 0;
  localparam int unsigned MC_MEN_BIT = 8;
  localparam int unsigned MC_SEN_BIT = 9;
  localparam int unsigned MC_TEN_BIT = 10;
  localparam int unsigned MC_TCODE_LSB = 16;
  localparam logic [CODE_W-1:0] MC_CODE_RST = 8'h00;

  // m codes that never raise the m strobe
  localparam logic [CODE_W-1:0] M_STOP = 8'h00;
  localparam logic [CODE_W-1:0] M_OPT_STOP = 8'h01;
  localparam logic [CODE_W-1:0] M_END = 8'h02;
  localparam logic [CODE_W-1:0] M_END_RWD = 8'h1E;
  localparam logic [CODE_W-1:0] M_SUB_CALL = 8'h62;
  localparam logic [CODE_W-1:0] M_SUB_RET = 8'h63;

  // interrupt bit positions
  localparam int unsigned IRQ_M = 0;
  localparam int unsigned IRQ_S = 1;
  localparam int unsigned IRQ_T = 2;
  localparam int unsigned IRQ_MAG1 = 3;
  localparam int unsigned IRQ_MAG2 = 4;
  localparam int unsigned IRQ_GCODE = 5;
  localparam int unsigned IRQ_MACRO = 6;
  localparam int unsigned IRQ_LIMIT = 7;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // status word as the plc sees it, lsb first: pos, neg, home, then single flags
  typedef struct packed {
    logic manual_data_input_mode;
    logic auto_mode;
    logic macro_init_done;
    logic gcode_ready_flag;
    logic prog_interrupt_active;
    logic magazine2_reset_done;
    logic magazine1_reset_done;
    logic t_code_strobe;
    logic s_code_strobe;
    logic m_code_strobe;
    logic [NPORT-1:0] home;
    logic [NPORT-1:0] neg_limit;
    logic [NPORT-1:0] pos_limit;
  } ncps_status_t;

  // code execution events from the interpreter
  typedef struct packed {
    logic m_exec;
    logic s_exec;
    logic t_exec;
    logic [CODE_W-1:0] m_val;
    logic [CODE_W-1:0] t_val;
  } ncps_code_t;

  // controller activity from the nc core, same clock
  typedef struct packed {
    logic auto_mode;
    logic manual_data_input_mode;
    logic m96_running;
    logic gcode_load_start;
    logic gcode_load_done;
    logic macro_setup_done;
    logic macro_id_valid;
  } ncps_core_t;

endpackage

// file: verilog/ncps_status.sv
// nc/plc status handshake: axis port flags, m/s/t strobes, controller status, apb slave
//
// Function
// - port positive limit pin sets positive flag
// - port negative limit pin sets negative flag
// - port home sensor sets home flag
// - executed m code sets strobe until ack
// - plc ack alone clears pending strobe
// - no m strobe for stops, calls, macros
// - executed s code sets strobe until ack
// - no s strobe for macro s code
// - executed t code sets strobe until ack
// - t strobe only in range, not macro
// - magazine 1 reset done, auto/manual input only
// - magazine 2 reset done, auto/manual input only
// - interruption flag follows m96 execution
// - g code ready after load finishes
// - macro init done in auto, valid id
// - automatic mode flag follows controller mode
module ncps_status #(
  parameter int unsigned NPORT = ncps_pkg::NPORT
) (
  input wire logic mclk_i, // 100 mhz scan clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [ncps_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [ncps_pkg::DATA_W-1:0] pwdata, // apb write data
  output logic [ncps_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [NPORT-1:0] pos_limit_i, // positive limit pins, ports 7..9
  input wire logic [NPORT-1:0] neg_limit_i, // negative limit pins, ports 7..9
  input wire logic [NPORT-1:0] home_i, // home sensor pins, ports 7..9
  input wire ncps_pkg::ncps_code_t code_i, // interpreter code events
  input wire ncps_pkg::ncps_core_t core_i, // nc core activity
  output ncps_pkg::ncps_status_t status_o, // status flags to plc
  output logic irq_o // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic m_excluded(input logic [ncps_pkg::CODE_W-1:0] code,
                                      input logic macro_en,
                                      input logic [ncps_pkg::CODE_W-1:0] macro_code);
    logic fixed;
    fixed = (code == ncps_pkg::M_STOP) || (code == ncps_pkg::M_OPT_STOP) ||
            (code == ncps_pkg::M_END) || (code == ncps_pkg::M_END_RWD) ||
            (code == ncps_pkg::M_SUB_CALL) || (code == ncps_pkg::M_SUB_RET);
    return fixed || (macro_en && (code == macro_code));
  endfunction

  function automatic logic reg_hit(input logic [ncps_pkg::ADDR_W-1:0] a,
                                   input logic [ncps_pkg::ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second

  logic [NPORT-1:0] pos_s1_r;
  logic [NPORT-1:0] pos_s2_r;
  logic [NPORT-1:0] neg_s1_r;
  logic [NPORT-1:0] neg_s2_r;
  logic [NPORT-1:0] home_s1_r;
  logic [NPORT-1:0] home_s2_r;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_s1_r <= '0;
      pos_s2_r <= '0;
      neg_s1_r <= '0;
      neg_s2_r <= '0;
      home_s1_r <= '0;
      home_s2_r <= '0;
    end
    else
    begin
      pos_s1_r <= pos_limit_i;
      pos_s2_r <= pos_s1_r;
      neg_s1_r <= neg_limit_i;
      neg_s2_r <= neg_s1_r;
      home_s1_r <= home_i;
      home_s2_r <= home_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  ncps_pkg::ncps_status_t status_r;
  ncps_pkg::ncps_status_t status_nxt;
  logic [ncps_pkg::CODE_W-1:0] tmin_r;
  logic [ncps_pkg::CODE_W-1:0] tmax_r;
  logic [ncps_pkg::CODE_W-1:0] mmacro_r;
  logic [ncps_pkg::CODE_W-1:0] tmacro_r;
  logic men_r;
  logic sen_r;
  logic ten_r;
  logic [ncps_pkg::NIRQ-1:0] irq_stat_r;
  logic [ncps_pkg::NIRQ-1:0] irq_stat_nxt;
  logic [ncps_pkg::NIRQ-1:0] irq_mask_r;
  logic [ncps_pkg::CODE_W-1:0] last_m_r;
  logic [ncps_pkg::DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;

  // one wait state: pready rises on the second access cycle
  wire pready_nxt = psel && penable && !pready_r;
  wire done_w = psel && penable && pready_r;
  wire hit_stat = reg_hit(paddr, ncps_pkg::STATUS_OFS);
  wire hit_ctrl = reg_hit(paddr, ncps_pkg::CTRL_OFS);
  wire hit_tr = reg_hit(paddr, ncps_pkg::TOOL_RANGE_OFS);
  wire hit_mc = reg_hit(paddr, ncps_pkg::MACRO_CFG_OFS);
  wire hit_is = reg_hit(paddr, ncps_pkg::IRQ_STAT_OFS);
  wire hit_im = reg_hit(paddr, ncps_pkg::IRQ_MASK_OFS);
  wire hit_lc = reg_hit(paddr, ncps_pkg::LAST_CODE_OFS);
  wire mapped = hit_stat || hit_ctrl || hit_tr || hit_mc || hit_is || hit_im || hit_lc;
  wire wr_w = done_w && pwrite;
  wire ack_w = wr_w && hit_ctrl && pwdata[ncps_pkg::CTRL_ACK_BIT];
  wire mag1_req_w = wr_w && hit_ctrl && pwdata[ncps_pkg::CTRL_MAG1_BIT];
  wire mag2_req_w = wr_w && hit_ctrl && pwdata[ncps_pkg::CTRL_MAG2_BIT];
  wire mode_ok_w = core_i.auto_mode || core_i.manual_data_input_mode;

  wire [ncps_pkg::DATA_W-1:0] rd_tr = {16'h0000, tmax_r, tmin_r};
  wire [ncps_pkg::DATA_W-1:0] rd_mc = {8'h00, tmacro_r, 5'h00, ten_r, sen_r, men_r, mmacro_r};
  wire [ncps_pkg::DATA_W-1:0] rd_mux =
    hit_stat ? ncps_pkg::DATA_W'(status_r) :
    hit_tr ? rd_tr :
    hit_mc ? rd_mc :
    hit_is ? ncps_pkg::DATA_W'(irq_stat_r) :
    hit_im ? ncps_pkg::DATA_W'(irq_mask_r) :
    hit_lc ? ncps_pkg::DATA_W'(last_m_r) : ncps_pkg::ZERO_WORD;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= ncps_pkg::ZERO_WORD;
    end
    else
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pready_nxt && !mapped;
      prdata_r <= (pready_nxt && !pwrite) ? rd_mux : ncps_pkg::ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; status has no write path of its own, only the control bits reach it

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tmin_r <= ncps_pkg::TR_MIN_RST;
      tmax_r <= ncps_pkg::TR_MAX_RST;
      mmacro_r <= ncps_pkg::MC_CODE_RST;
      tmacro_r <= ncps_pkg::MC_CODE_RST;
      men_r <= 1'b0;
      sen_r <= 1'b0;
      ten_r <= 1'b0;
      irq_mask_r <= '0;
    end
    else if (wr_w)
    begin
      if (hit_tr)
      begin
        tmin_r <= pwdata[ncps_pkg::TR_MIN_LSB +: ncps_pkg::CODE_W];
        tmax_r <= pwdata[ncps_pkg::TR_MAX_LSB +: ncps_pkg::CODE_W];
      end
      if (hit_mc)
      begin
        mmacro_r <= pwdata[ncps_pkg::MC_MCODE_LSB +: ncps_pkg::CODE_W];
        tmacro_r <= pwdata[ncps_pkg::MC_TCODE_LSB +: ncps_pkg::CODE_W];
        men_r <= pwdata[ncps_pkg::MC_MEN_BIT];
        sen_r <= pwdata[ncps_pkg::MC_SEN_BIT];
        ten_r <= pwdata[ncps_pkg::MC_TEN_BIT];
      end
      if (hit_im)
      begin
        irq_mask_r <= pwdata[ncps_pkg::NIRQ-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  wire m_set_w = code_i.m_exec && !m_excluded(code_i.m_val, men_r, mmacro_r);
  wire s_set_w = code_i.s_exec && !sen_r;
  wire t_inrange_w = (code_i.t_val >= tmin_r) && (code_i.t_val <= tmax_r);
  wire t_macro_w = ten_r && (code_i.t_val == tmacro_r);
  wire t_set_w = code_i.t_exec && t_inrange_w && !t_macro_w;
  wire macro_set_w = core_i.macro_setup_done && core_i.auto_mode && core_i.macro_id_valid;

  always_comb
  begin
    status_nxt = status_r;
    status_nxt.pos_limit = pos_s2_r;
    status_nxt.neg_limit = neg_s2_r;
    status_nxt.home = home_s2_r;
    // strobes: a new code in the ack cycle keeps the strobe set
    status_nxt.m_code_strobe = m_set_w || (status_r.m_code_strobe && !ack_w);
    status_nxt.s_code_strobe = s_set_w || (status_r.s_code_strobe && !ack_w);
    status_nxt.t_code_strobe = t_set_w || (status_r.t_code_strobe && !ack_w);
    if (mag1_req_w && mode_ok_w)
    begin
      status_nxt.magazine1_reset_done = 1'b1;
    end
    if (mag2_req_w && mode_ok_w)
    begin
      status_nxt.magazine2_reset_done = 1'b1;
    end
    status_nxt.prog_interrupt_active = core_i.m96_running;
    if (core_i.gcode_load_done)
    begin
      status_nxt.gcode_ready_flag = 1'b1;
    end
    else if (core_i.gcode_load_start)
    begin
      status_nxt.gcode_ready_flag = 1'b0;
    end
    // macro init is only meaningful while automatic mode lasts
    status_nxt.macro_init_done = macro_set_w ||
                                 (status_r.macro_init_done && core_i.auto_mode);
    status_nxt.auto_mode = core_i.auto_mode;
    status_nxt.manual_data_input_mode = core_i.manual_data_input_mode;
  end

  // status_r is written only from status_nxt, which sees pwdata only through the control ack and magazine request bits
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      status_r <= '0;
      last_m_r <= '0;
    end
    else
    begin
      status_r <= status_nxt;
      if (m_set_w)
      begin
        last_m_r <= code_i.m_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: m/s/t and macro set events and rising magazine, g code and limit flags set sticky bits, write one clears, set wins

  logic [ncps_pkg::NIRQ-1:0] irq_ev_w;
  assign irq_ev_w[ncps_pkg::IRQ_M] = m_set_w;
  assign irq_ev_w[ncps_pkg::IRQ_S] = s_set_w;
  assign irq_ev_w[ncps_pkg::IRQ_T] = t_set_w;
  assign irq_ev_w[ncps_pkg::IRQ_MAG1] = status_nxt.magazine1_reset_done &&
                                        !status_r.magazine1_reset_done;
  assign irq_ev_w[ncps_pkg::IRQ_MAG2] = status_nxt.magazine2_reset_done &&
                                        !status_r.magazine2_reset_done;
  assign irq_ev_w[ncps_pkg::IRQ_GCODE] = status_nxt.gcode_ready_flag &&
                                         !status_r.gcode_ready_flag;
  assign irq_ev_w[ncps_pkg::IRQ_MACRO] = macro_set_w;
  assign irq_ev_w[ncps_pkg::IRQ_LIMIT] = |((pos_s2_r & ~status_r.pos_limit) |
                                           (neg_s2_r & ~status_r.neg_limit));

  wire [ncps_pkg::NIRQ-1:0] irq_clr_w = (wr_w && hit_is) ? pwdata[ncps_pkg::NIRQ-1:0] : '0;
  assign irq_stat_nxt = irq_ev_w | (irq_stat_r & ~irq_clr_w);

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign status_o = status_r;
  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  pos_limit_a: assert property (pos_s1_r[0] |-> ##2 status_r.pos_limit[0])
    else $error("positive limit flag missed");
  neg_limit_a: assert property (neg_s2_r != status_r.neg_limit
                                |=> status_r.neg_limit == $past(neg_s2_r))
    else $error("negative limit flag wrong");
  home_drop_a: assert property ($fell(home_s2_r[NPORT-1]) |=> !status_r.home[NPORT-1])
    else $error("home flag did not drop");
  m_hold_a: assert property (status_r.m_code_strobe && !ack_w |=> status_r.m_code_strobe)
    else $error("m strobe lost without ack");
  ack_clear_a: assert property ($fell(status_r.s_code_strobe) |-> $past(ack_w))
    else $error("s strobe cleared without ack");
  m_excl_a: assert property (code_i.m_exec && code_i.m_val == ncps_pkg::M_END_RWD &&
                             !status_r.m_code_strobe |=> !status_r.m_code_strobe)
    else $error("m strobe raised for excluded code");
  s_set_a: assert property (code_i.s_exec && !sen_r |=> status_r.s_code_strobe)
    else $error("s strobe not raised");
  t_range_a: assert property ($rose(status_r.t_code_strobe)
                              |-> $past(code_i.t_val) <= $past(tmax_r))
    else $error("t strobe out of range");
  mag1_mode_a: assert property ($rose(status_r.magazine1_reset_done)
                                |-> $past(mode_ok_w))
    else $error("magazine reset outside auto or manual input");
  prog_int_a: assert property (core_i.m96_running |=> status_r.prog_interrupt_active)
    else $error("interruption flag not set");
  macro_init_a: assert property ($rose(status_r.macro_init_done)
                                 |-> $past(core_i.auto_mode && core_i.macro_id_valid))
    else $error("macro init outside auto or bad id");
  stat_ro_a: assert property (wr_w && hit_stat
                              |=> $stable(status_r.magazine1_reset_done) &&
                                  $stable(status_r.magazine2_reset_done))
    else $error("status changed by write");
  auto_flag_a: assert property (core_i.auto_mode ##1 core_i.auto_mode
                                |=> status_r.auto_mode)
    else $error("auto flag not following mode");
  // exclusions are checked from an idle strobe, so a pending one cannot hide a wrong set
  t_min_a: assert property (code_i.t_exec && code_i.t_val == tmin_r &&
                            tmin_r <= tmax_r && !(ten_r && code_i.t_val == tmacro_r)
                            |=> status_r.t_code_strobe)
    else $error("t strobe missed at range start");
  t_macro_a: assert property (code_i.t_exec && ten_r && code_i.t_val == tmacro_r &&
                              !status_r.t_code_strobe |=> !status_r.t_code_strobe)
    else $error("t strobe raised for macro code");
  m_macro_a: assert property (code_i.m_exec && men_r && code_i.m_val == mmacro_r &&
                              !status_r.m_code_strobe |=> !status_r.m_code_strobe)
    else $error("m strobe raised for macro code");
  s_macro_a: assert property (code_i.s_exec && sen_r && !status_r.s_code_strobe
                              |=> !status_r.s_code_strobe)
    else $error("s strobe raised for macro code");
  mag2_mode_a: assert property ($rose(status_r.magazine2_reset_done)
                                |-> $past(core_i.auto_mode || core_i.manual_data_input_mode))
    else $error("magazine 2 reset outside auto or manual input");
  mag1_hold_a: assert property (status_r.magazine1_reset_done
                                |=> status_r.magazine1_reset_done)
    else $error("magazine 1 done flag dropped");
  mag2_hold_a: assert property (status_r.magazine2_reset_done
                                |=> status_r.magazine2_reset_done)
    else $error("magazine 2 done flag dropped");
  gcode_rdy_a: assert property (core_i.gcode_load_done |=> status_r.gcode_ready_flag)
    else $error("g code ready not set");
  int_drop_a: assert property (!core_i.m96_running |=> !status_r.prog_interrupt_active)
    else $error("interruption flag did not drop");
  home_set_a: assert property (home_s1_r[0] |-> ##2 status_r.home[0])
    else $error("home flag missed");
  auto_drop_a: assert property (!core_i.auto_mode |=> !status_r.auto_mode)
    else $error("auto flag did not drop");
  macro_drop_a: assert property (!core_i.auto_mode |=> !status_r.macro_init_done)
    else $error("macro init kept outside auto");

  m_ack_c: cover property (status_r.m_code_strobe ##1 ack_w ##1 !status_r.m_code_strobe);
  t_set_c: cover property (t_set_w ##1 status_r.t_code_strobe);
  mag2_c: cover property (mag2_req_w && mode_ok_w ##1 status_r.magazine2_reset_done);
  irq_c: cover property ($rose(irq_o));
  s_excl_c: cover property (code_i.s_exec && sen_r ##1 !status_r.s_code_strobe);

endmodule

// file: testbench/ncps_plc_model.sv
// plc side model: apb master that reads the status block and acknowledges strobes
module ncps_plc_model (
  input wire logic mclk_i, // scan clock
  output logic psel, // apb select
  output logic penable, // apb access phase
  output logic pwrite, // apb direction
  output logic [ncps_pkg::ADDR_W-1:0] paddr, // apb byte address
  output logic [ncps_pkg::DATA_W-1:0] pwdata, // apb write data
  input wire logic [ncps_pkg::DATA_W-1:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released address and data lines do not keep their last value; pwrite does
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge mclk_i);
  endtask
  // ladder scan delay before the shared completion acknowledge
  task automatic ack(input int dly);
    logic [31:0] r;
    logic e;
    repeat (dly) @(posedge mclk_i);
    xfer(1'b1, ncps_pkg::CTRL_OFS, 32'h0000_0001, r, e);
  endtask
endmodule

// file: testbench/ncps_status_tb.sv
// self-checking bench of the nc/plc status block
module ncps_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAC_M = 8'h2A;
  localparam logic [7:0] MAC_T = 8'h05;
  localparam logic [7:0] T_MIN = 8'h03;
  localparam logic [7:0] T_MAX = 8'h09;
  localparam logic [7:0] MTAB [8] = '{ncps_pkg::M_STOP, ncps_pkg::M_OPT_STOP,
    ncps_pkg::M_END, ncps_pkg::M_END_RWD, ncps_pkg::M_SUB_CALL, ncps_pkg::M_SUB_RET, MAC_M, 8'h03};
  localparam logic [7:0] TTAB [5] = '{8'h02, 8'h03, 8'h05, 8'h09, 8'h0A};
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] seed = 32'h7f84_8dc3;
  logic [2:0] pos = 3'h0, neg = 3'h0, home = 3'h0;
  ncps_pkg::ncps_code_t code = '0;
  ncps_pkg::ncps_core_t core = '0;
  ncps_pkg::ncps_status_t st;
  wire logic [2:0] strb = {st.t_code_strobe, st.s_code_strobe, st.m_code_strobe};
  int failures = 0, check_count = 0, cyc = 0;
  initial forever #5 mclk_i = ~mclk_i;
  ncps_status u_ncps_status (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_limit_i(pos), .neg_limit_i(neg),
    .home_i(home), .code_i(code), .core_i(core), .status_o(st), .irq_o(irq));
  ncps_plc_model u_ncps_plc_model (.mclk_i(mclk_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic exp_m(input logic [7:0] c);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 7; i++)
      hit = hit || (c == MTAB[i]);
    return !hit;
  endfunction
  function automatic logic exp_t(input logic [7:0] v);
    return v >= T_MIN && v <= T_MAX && v != MAC_T;
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ncps_plc_model.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    u_ncps_plc_model.xfer(1'b0, a, 32'h0000_0000, r, e);
    chk_word(r, exp);
  endtask
  task automatic pulse_core(input int b);
    core[b] <= 1'b1;
    step(1);
    core[b] <= 1'b0;
    step(1);
  endtask
  // one exec pulse of kind k (0 m, 1 s, 2 t); a raised strobe must wait for the ack
  task automatic run_code(input int k, input logic [7:0] v, input logic x);
    code.m_val <= v;
    code.t_val <= v;
    code.m_exec <= k == 0;
    code.s_exec <= k == 1;
    code.t_exec <= k == 2;
    step(1);
    code <= '0;
    step(1);
    chk_bit(strb[k], x);
    if (x)
    begin
      step(3);
      chk_bit(strb[k], 1'b1);
      u_ncps_plc_model.ack(int'(seed[2:0]));
      seed = lfsr(seed);
      chk_bit(strb[k], 1'b0);
    end
  endtask
  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    step(3);
    sys_rst_i <= 1'b0;
    step(1);
    rchk(ncps_pkg::TOOL_RANGE_OFS, {16'h0000, ncps_pkg::TR_MAX_RST, ncps_pkg::TR_MIN_RST});
    rchk(ncps_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    rchk(8'h1C, 32'h0000_0000);
    chk_bit(e, 1'b1);
    test_end("registers");
    repeat (6)
    begin
      seed = lfsr(seed);
      pos <= seed[2:0];
      neg <= seed[5:3];
      home <= seed[8:6];
      step(4);
      chk_word({23'h00_0000, st[8:0]}, {23'h00_0000, seed[8:0]});
    end
    wr(ncps_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    rchk(ncps_pkg::STATUS_OFS, {23'h00_0000, seed[8:0]});
    test_end("pins");
    wr(ncps_pkg::TOOL_RANGE_OFS, {16'h0000, T_MAX, T_MIN});
    wr(ncps_pkg::MACRO_CFG_OFS, {8'h00, MAC_T, 8'h05, MAC_M});
    foreach (MTAB[i]) run_code(0, MTAB[i], exp_m(MTAB[i]));
    repeat (6)
    begin
      seed = lfsr(seed);
      run_code(0, seed[7:0], exp_m(seed[7:0]));
    end
    run_code(1, 8'h00, 1'b1);
    wr(ncps_pkg::MACRO_CFG_OFS, {8'h00, MAC_T, 8'h07, MAC_M});
    run_code(1, 8'h00, 1'b0);
    foreach (TTAB[i]) run_code(2, TTAB[i], exp_t(TTAB[i]));
    code <= '{1'b1, 1'b0, 1'b1, 8'h03, 8'h04};
    step(1);
    code <= '0;
    step(1);
    chk_word({29'h0000_0000, strb}, 32'h0000_0005);
    u_ncps_plc_model.ack(0);
    chk_word({29'h0000_0000, strb}, 32'h0000_0000);
    test_end("strobes");
    wr(ncps_pkg::CTRL_OFS, 32'h0000_0006);
    chk_word({30'h0000_0000, st.magazine2_reset_done, st.magazine1_reset_done},
      32'h0000_0000);
    core.manual_data_input_mode <= 1'b1;
    wr(ncps_pkg::CTRL_OFS, 32'h0000_0002);
    chk_word({30'h0000_0000, st.manual_data_input_mode, st.magazine1_reset_done},
      32'h0000_0003);
    core.manual_data_input_mode <= 1'b0;
    core.auto_mode <= 1'b1;
    wr(ncps_pkg::CTRL_OFS, 32'h0000_0004);
    chk_word({30'h0000_0000, st.magazine2_reset_done, st.auto_mode}, 32'h0000_0003);
    core.m96_running <= 1'b1;
    step(2);
    chk_bit(st.prog_interrupt_active, 1'b1);
    core.m96_running <= 1'b0;
    step(2);
    chk_bit(st.prog_interrupt_active, 1'b0);
    pulse_core(2);
    chk_bit(st.gcode_ready_flag, 1'b1);
    pulse_core(3);
    chk_bit(st.gcode_ready_flag, 1'b0);
    pulse_core(1);
    chk_bit(st.macro_init_done, 1'b0);
    core.macro_id_valid <= 1'b1;
    step(1);
    pulse_core(1);
    chk_bit(st.macro_init_done, 1'b1);
    test_end("status");
    wr(ncps_pkg::IRQ_STAT_OFS, 32'h0000_00FF);
    wr(ncps_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    run_code(0, 8'h03, 1'b1);
    chk_bit(irq, 1'b1);
    rchk(ncps_pkg::IRQ_STAT_OFS, 32'h0000_0001);
    rchk(ncps_pkg::LAST_CODE_OFS, 32'h0000_0003);
    wr(ncps_pkg::IRQ_MASK_OFS, 32'h0000_0000);
    step(1);
    chk_bit(irq, 1'b0);
    wr(ncps_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    step(1);
    chk_bit(irq, 1'b1);
    wr(ncps_pkg::IRQ_STAT_OFS, 32'h0000_0001);
    step(1);
    chk_bit(irq, 1'b0);
    test_end("interrupt");
    // mid-run reset: sticky flags and configuration must return to their reset values
    sys_rst_i <= 1'b1;
    step(2);
    sys_rst_i <= 1'b0;
    step(1);
    chk_word({12'h000, irq, st}, 32'h0000_0000);
    rchk(ncps_pkg::TOOL_RANGE_OFS, {16'h0000, ncps_pkg::TR_MAX_RST, ncps_pkg::TR_MIN_RST});
    test_end("reset");
    conclude();
  end
endmodule
